//--- src/tcx_core.sv
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - one independent 16-bit counter channel; the unit instantiates up to five
// - directions up, down and alternating up/down chosen by configuration
// - counting begins only once software sets counter-on, bit 0
// - clearing counter-on freezes the counter; all registers keep values
// - counter clock is the system clock gated by the counter enable
// - divider field bits 10:8 divides counter clock by two to the field
// - divider ignored in quadrature and dead-time modes
// - each event picks rising, falling, both edges or level
// - command register writes raise the same events as hardware triggers
// - reload loads zero and starts counting in up or down mode
// - reload loads one in up/down mode
// - in quadrature mode reload is the index event
// - start resumes counting from the current value unchanged
// - in quadrature mode the start trigger is phase B
// - count event steps by direction; quadrature treats it as phase A
// - stop halts counting until a later start or reload, except in quadrature mode where it is ignored
// - in PWM modes stop kills, forcing PWM lines disabled
// - capture copies count to capture, capture to capture buffer
// - in PWM modes capture swaps compare and period with buffers
// - every hardware trigger is synchronised to the system clock
// - output triggers are generated on the system clock
// - interrupt request raised on terminal count or capture/compare
// - overflow at period counting up, underflow at zero counting down
// - capture/compare on compare match while running or on capture outside PWM modes
// - terminal count request set by hardware, cleared by writing one
module tcx_core #(
  parameter int CW = tcx_pkg::CNT_W
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [tcx_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // hardware triggers: reload, start, stop, count, capture
  input wire logic [tcx_pkg::NUM_EV-1:0] trig_i,
  // output triggers, interrupt and lines
  output logic ov_o,
  output logic un_o,
  output logic cc_o,
  output logic irq_o,
  output logic line_o,
  output logic line_compl_o
);
  import tcx_pkg::*;

  typedef struct packed {
    logic on;
    logic [2:0] mode;
    logic [1:0] dir;
    logic [2:0] div;
    logic [2*NUM_EV-1:0] trsel;
    logic [CW-1:0] cnt;
    logic [CW-1:0] cmp;
    logic [CW-1:0] cmpb;
    logic [CW-1:0] per;
    logic [CW-1:0] perb;
    logic [CW-1:0] cap;
    logic [CW-1:0] capb;
    logic [1:0] intr;
    logic run;
    logic down;
    logic kill;
    logic cpend;
    logic qa;
    logic qb;
    logic ovp;
    logic unp;
    logic ccp;
    logic ov;
    logic un;
    logic cc;
    logic line;
    logic linec;
    logic irq;
    logic [7:0] dcnt;
    logic [31:0] rdata;
  } tcx_state_t;

  tcx_state_t s_q;
  tcx_state_t s_d;

  logic [NUM_EV-1:0] hw_evt;
  logic [NUM_EV-1:0] lvl;
  logic [NUM_EV-1:0] cmd_evt;
  logic [NUM_EV-1:0] ev;
  logic is_pwm;
  logic is_quad;
  logic no_div;
  logic tick;
  logic [7:0] dmask;
  logic do_step;
  logic dn;
  logic [CW:0] nxt;
  logic qmove;
  logic ov_now;
  logic un_now;
  logic cc_now;
  logic [31:0] rmux;

  // ==========================================
  // helpers
  function automatic logic [7:0] tcx_div_mask(input logic [2:0] d);
    tcx_div_mask = 8'((9'h001 << d) - 9'h001);
  endfunction

  // msb flags a wrap; lower bits the new count
  function automatic logic [CW:0] tcx_step(
    input logic [CW-1:0] c,
    input logic [CW-1:0] p,
    input logic down_i
  );
    if (down_i) begin
      tcx_step = (c == '0) ? {1'b1, p} : {1'b0, CW'(c - 1'b1)};
    end else begin
      tcx_step = (c == p) ? {1'b1, {CW{1'b0}}} : {1'b0, CW'(c + 1'b1)};
    end
  endfunction

  function automatic logic tcx_pwm_mode(input logic [2:0] m);
    tcx_pwm_mode = (m == MODE_PWM) || (m == MODE_DEAD_TIME_PWM) || (m == MODE_PWM_PR);
  endfunction

  // ==========================================
  // trigger synchronisers
  tcx_trig_sync #(
    .N(NUM_EV)
  ) u_trig (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .trig_i(trig_i),
    .sel_i(s_q.trsel),
    .evt_o(hw_evt),
    .lvl_o(lvl)
  );

  // ==========================================
  // event merge and prescaler
  assign cmd_evt = (wr_i && addr_i == OFS_EV_CMD) ? wdata_i[NUM_EV-1:0] : '0;
  // events only act while the counter is on
  assign ev = (hw_evt | cmd_evt) & {NUM_EV{s_q.on}};
  assign is_pwm = tcx_pwm_mode(s_q.mode);
  assign is_quad = (s_q.mode == MODE_QUAD);
  assign no_div = is_quad || (s_q.mode == MODE_DEAD_TIME_PWM);
  assign dmask = tcx_div_mask(s_q.div);
  // gated clock realised as an enable: no clock gating cell, no skew
  assign tick = s_q.on && (no_div || ((s_q.dcnt & dmask) == dmask));
  assign qmove = (lvl[EV_COUNT] != s_q.qa) || (lvl[EV_START] != s_q.qb);

  // ==========================================
  // register read mux
  always_comb begin
    case (addr_i)
      OFS_BLK_CTRL: rmux = {31'h0, s_q.on};
      OFS_CH_CTRL: rmux = {5'h0, s_q.mode, 6'h0, s_q.dir, 5'h0, s_q.div, 8'h0};
      OFS_TRG_CFG: rmux = 32'(s_q.trsel);
      OFS_TALLY: rmux = 32'(s_q.cnt);
      OFS_CMP: rmux = 32'(s_q.cmp);
      OFS_CMP_BUF: rmux = 32'(s_q.cmpb);
      OFS_PER: rmux = 32'(s_q.per);
      OFS_PER_BUF: rmux = 32'(s_q.perb);
      OFS_CAP: rmux = 32'(s_q.cap);
      OFS_CAP_BUF: rmux = 32'(s_q.capb);
      OFS_INTR: rmux = {30'h0, s_q.intr};
      OFS_STATUS: rmux = {29'h0, s_q.kill, s_q.down, s_q.run};
      default: rmux = 32'h0;
    endcase
  end

  // ==========================================
  // next state
  always_comb begin
    s_d = s_q;
    do_step = 1'b0;
    dn = 1'b0;
    nxt = '0;
    ov_now = 1'b0;
    un_now = 1'b0;
    cc_now = 1'b0;
    s_d.rdata = rd_i ? rmux : 32'h0;

    // software writes
    if (wr_i) begin
      case (addr_i)
        OFS_BLK_CTRL: s_d.on = wdata_i[BLK_ON_BIT];
        OFS_CH_CTRL: begin
          s_d.mode = wdata_i[MODE_LSB +: 3];
          s_d.dir = wdata_i[DIR_LSB +: 2];
          s_d.div = wdata_i[DIV_LSB +: 3];
        end
        OFS_TRG_CFG: s_d.trsel = wdata_i[2*NUM_EV-1:0];
        OFS_TALLY: s_d.cnt = wdata_i[CW-1:0];
        OFS_CMP: s_d.cmp = wdata_i[CW-1:0];
        OFS_CMP_BUF: s_d.cmpb = wdata_i[CW-1:0];
        OFS_PER: s_d.per = wdata_i[CW-1:0];
        OFS_PER_BUF: s_d.perb = wdata_i[CW-1:0];
        OFS_INTR: s_d.intr = s_q.intr & ~wdata_i[1:0];
        default: ;
      endcase
    end

    // prescaler runs only while enabled; held otherwise
    if (s_q.on) begin
      s_d.dcnt = 8'(s_q.dcnt + 8'h01);
    end

    if (s_q.on) begin
      if (is_quad) begin
        // phase a on the count trigger, phase b on the start trigger
        s_d.qa = lvl[EV_COUNT];
        s_d.qb = lvl[EV_START];
        if (s_q.run && qmove) begin
          do_step = 1'b1;
          dn = ~(lvl[EV_COUNT] ^ s_q.qb);
        end
      end else begin
        if (ev[EV_COUNT]) begin
          s_d.cpend = 1'b1;
        end
        if (ev[EV_STOP]) begin
          s_d.run = 1'b0;
          if (is_pwm) begin
            s_d.kill = 1'b1;
          end
        end else if (ev[EV_START]) begin
          s_d.run = 1'b1;
          s_d.kill = 1'b0;
        end
        // missed events: several counts in one divided period merge
        if (s_q.run && tick && (s_q.cpend || ev[EV_COUNT])) begin
          do_step = 1'b1;
          s_d.cpend = 1'b0;
          dn = (s_q.dir == DIR_DOWN) || (s_q.dir[1] && s_q.down);
        end
      end

      if (do_step) begin
        if (s_q.dir[1] && !is_quad) begin
          // alternating: turn at period and at zero
          if (!s_q.down && s_q.cnt == s_q.per) begin
            s_d.down = 1'b1;
            s_d.cnt = CW'(s_q.cnt - 1'b1);
            ov_now = 1'b1;
          end else if (s_q.down && s_q.cnt == '0) begin
            s_d.down = 1'b0;
            s_d.cnt = CW'(s_q.cnt + 1'b1);
            un_now = 1'b1;
          end else begin
            nxt = tcx_step(s_q.cnt, s_q.per, s_q.down);
            s_d.cnt = nxt[CW-1:0];
          end
        end else begin
          nxt = tcx_step(s_q.cnt, s_q.per, dn);
          s_d.cnt = nxt[CW-1:0];
          ov_now = nxt[CW] && !dn;
          un_now = nxt[CW] && dn;
        end
        if (s_d.cnt == s_q.cmp) begin
          cc_now = 1'b1;
        end
      end

      if (ev[EV_CAPT]) begin
        if (is_pwm) begin
          s_d.cmp = s_q.cmpb;
          s_d.cmpb = s_q.cmp;
          s_d.per = s_q.perb;
          s_d.perb = s_q.per;
        end else begin
          s_d.cap = s_q.cnt;
          s_d.capb = s_q.cap;
          cc_now = 1'b1;
        end
      end

      // reload wins over start, stop and count in the same cycle; a capture still acts
      if (ev[EV_RELOAD]) begin
        s_d.cnt = (s_q.dir[1] && !is_quad) ? CW'(1) : CW'(0);
        s_d.run = 1'b1;
        s_d.kill = 1'b0;
        s_d.down = 1'b0;
        s_d.cpend = 1'b0;
        if (is_quad) begin
          ov_now = 1'b1;
        end
      end
    end

    // hardware set wins over a software clear in the same cycle
    if (ov_now || un_now) begin
      s_d.intr[INTR_TC_BIT] = 1'b1;
    end
    if (cc_now) begin
      s_d.intr[INTR_CC_BIT] = 1'b1;
    end

    // output triggers held two system clocks
    s_d.ovp = ov_now;
    s_d.unp = un_now;
    s_d.ccp = cc_now;
    s_d.ov = ov_now || s_q.ovp;
    s_d.un = un_now || s_q.unp;
    s_d.cc = cc_now || s_q.ccp;
    s_d.irq = |s_d.intr;
    s_d.line = tcx_pwm_mode(s_d.mode) && !s_d.kill && (s_d.cnt < s_d.cmp);
    s_d.linec = tcx_pwm_mode(s_d.mode) && !s_d.kill && !(s_d.cnt < s_d.cmp);
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
      s_q.trsel <= TRG_CFG_RST;
      s_q.per <= PER_RST;
      s_q.perb <= PER_RST;
      s_q.cmp <= CMP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign ov_o = s_q.ov;
  assign un_o = s_q.un;
  assign cc_o = s_q.cc;
  assign irq_o = s_q.irq;
  assign line_o = s_q.line;
  assign line_compl_o = s_q.linec;

  // ==========================================
  // checks
  property p_off_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (!s_q.on && !wr_i) |=> $stable(s_q.cnt) && $stable(s_q.cap);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("count moved while off");

  property p_reload_zero;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (ev[EV_RELOAD] && !s_q.dir[1]) |=> (s_q.cnt == '0) && s_q.run;
  endproperty
  a_reload_zero: assert property (p_reload_zero) else $error("reload did not load zero");

  property p_reload_one;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (ev[EV_RELOAD] && s_q.dir[1] && !is_quad) |=> (s_q.cnt == CW'(1)) && !s_q.down;
  endproperty
  a_reload_one: assert property (p_reload_one) else $error("reload did not load one");

  property p_start_keeps;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (ev[EV_START] && !ev[EV_STOP] && !ev[EV_RELOAD] && !is_quad && !s_q.run && !wr_i)
      |=> s_q.run && (s_q.cnt == $past(s_q.cnt));
  endproperty
  a_start_keeps: assert property (p_start_keeps) else $error("start altered count");

  property p_stop_halts;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (ev[EV_STOP] && !ev[EV_RELOAD] && !is_quad) ##1 (!ev[EV_START] && !ev[EV_RELOAD] && !wr_i)
      |=> $stable(s_q.cnt);
  endproperty
  a_stop_halts: assert property (p_stop_halts) else $error("count moved after stop");

  property p_kill_lines;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (ev[EV_STOP] && !ev[EV_RELOAD] && is_pwm && !wr_i) |=> !line_o && !line_compl_o;
  endproperty
  a_kill_lines: assert property (p_kill_lines) else $error("lines active after kill");

  property p_capture;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (ev[EV_CAPT] && !is_pwm) |=> (s_q.cap == $past(s_q.cnt)) && (s_q.capb == $past(s_q.cap))
      ##1 cc_o;
  endproperty
  a_capture: assert property (p_capture) else $error("capture copy wrong");

  property p_switch;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (ev[EV_CAPT] && is_pwm && !wr_i)
      |=> (s_q.cmp == $past(s_q.cmpb)) && (s_q.per == $past(s_q.perb));
  endproperty
  a_switch: assert property (p_switch) else $error("switch did not swap");

  property p_tc_sticky;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (s_q.intr[INTR_TC_BIT] && !(wr_i && addr_i == OFS_INTR && wdata_i[INTR_TC_BIT]))
      |=> s_q.intr[INTR_TC_BIT] && irq_o;
  endproperty
  a_tc_sticky: assert property (p_tc_sticky) else $error("tc request lost");

  property p_ov_pulse;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $rose(s_q.ovp) |-> ov_o ##1 ov_o;
  endproperty
  a_ov_pulse: assert property (p_ov_pulse) else $error("overflow trigger not two cycles");
endmodule
`default_nettype wire

//--- src/tcx_pkg.sv
`default_nettype none
package tcx_pkg;
  // ==========================================
  // widths
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int NUM_EV = 5;
  localparam int MAX_CH = 5;
  // ==========================================
  // register offsets
  localparam logic [7:0] OFS_BLK_CTRL = 8'h00;
  localparam logic [7:0] OFS_EV_CMD = 8'h04;
  localparam logic [7:0] OFS_CH_CTRL = 8'h08;
  localparam logic [7:0] OFS_TRG_CFG = 8'h0c;
  localparam logic [7:0] OFS_TALLY = 8'h10;
  localparam logic [7:0] OFS_CMP = 8'h14;
  localparam logic [7:0] OFS_CMP_BUF = 8'h18;
  localparam logic [7:0] OFS_PER = 8'h1c;
  localparam logic [7:0] OFS_PER_BUF = 8'h20;
  localparam logic [7:0] OFS_CAP = 8'h24;
  localparam logic [7:0] OFS_CAP_BUF = 8'h28;
  localparam logic [7:0] OFS_INTR = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  // ==========================================
  // field positions
  localparam int BLK_ON_BIT = 0;
  localparam int DIV_LSB = 8;
  localparam int DIR_LSB = 16;
  localparam int MODE_LSB = 24;
  localparam int INTR_TC_BIT = 0;
  localparam int INTR_CC_BIT = 1;
  // ==========================================
  // event indices and trigger selections
  localparam int EV_RELOAD = 0;
  localparam int EV_START = 1;
  localparam int EV_STOP = 2;
  localparam int EV_COUNT = 3;
  localparam int EV_CAPT = 4;
  localparam logic [1:0] TRG_RISE = 2'h0;
  localparam logic [1:0] TRG_FALL = 2'h1;
  localparam logic [1:0] TRG_BOTH = 2'h2;
  localparam logic [1:0] TRG_LEVEL = 2'h3;
  // ==========================================
  // modes and directions
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_CAPTURE = 3'h2;
  localparam logic [2:0] MODE_QUAD = 3'h3;
  localparam logic [2:0] MODE_PWM = 3'h4;
  localparam logic [2:0] MODE_DEAD_TIME_PWM = 3'h5;
  localparam logic [2:0] MODE_PWM_PR = 3'h6;
  localparam logic [1:0] DIR_UP = 2'h0;
  localparam logic [1:0] DIR_DOWN = 2'h1;
  localparam logic [1:0] DIR_UPDN = 2'h2;
  // ==========================================
  // reset values
  localparam logic [9:0] TRG_CFG_RST = 10'h0c0;
  localparam logic [15:0] PER_RST = 16'hffff;
  localparam logic [15:0] CMP_RST = 16'h0000;
endpackage
`default_nettype wire

//--- src/tcx_trig_sync.sv
`timescale 1ns/10ps
`default_nettype none
module tcx_trig_sync #(
  parameter int N = 5
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // raw triggers and per-event selection
  input wire logic [N-1:0] trig_i,
  input wire logic [2*N-1:0] sel_i,
  // detected events and synchronised levels
  output logic [N-1:0] evt_o,
  output logic [N-1:0] lvl_o
);
  import tcx_pkg::*;

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] prev;
  } tcx_trig_state_t;

  tcx_trig_state_t s_q;
  tcx_trig_state_t s_d;

  // ==========================================
  // synchroniser and edge detect
  always_comb begin
    s_d = s_q;
    s_d.s1 = trig_i;
    s_d.s2 = s_q.s1;
    s_d.prev = s_q.s2;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // only s2 and prev are looked at; s1 feeds s2 alone
  always_comb begin
    for (int i = 0; i < N; i++) begin
      case (sel_i[2*i +: 2])
        TRG_RISE: evt_o[i] = s_q.s2[i] & ~s_q.prev[i];
        TRG_FALL: evt_o[i] = ~s_q.s2[i] & s_q.prev[i];
        TRG_BOTH: evt_o[i] = s_q.s2[i] ^ s_q.prev[i];
        default: evt_o[i] = s_q.s2[i];
      endcase
    end
  end

  assign lvl_o = s_q.s2;
endmodule
`default_nettype wire

//--- verification/tcx_trig_src.sv
`timescale 1ns/10ps
`default_nettype none
module tcx_trig_src (
  // clock
  input wire logic sys_clk_i,
  // trigger lines towards the core
  output logic [4:0] trig_o
);
  initial trig_o = 5'h00;
  // ==========================================
  // source behaviour
  // lines move just after an edge, like any synchronous source
  task automatic hold(input int idx, input logic v);
    @(posedge sys_clk_i);
    trig_o[idx] <= v;
  endtask
  // high for exactly n cycles, then back low
  task automatic pulse(input int idx, input int n);
    hold(idx, 1'b1);
    repeat (n - 1) @(posedge sys_clk_i);
    hold(idx, 1'b0);
  endtask
endmodule
`default_nettype wire

//--- verification/tcx_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tcx_core_tb;
  import tcx_pkg::*;
  logic sys_clk_i;
  logic nrst_i;
  logic wr_i;
  logic rd_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i;
  logic [31:0] rdata_o;
  logic [4:0] trig_i;
  logic ov_o, un_o, cc_o, irq_o, line_o, line_compl_o;
  logic [31:0] q;
  int err_count, samples_checked, ov_hi, un_hi, cc_hi, base;
  logic [31:0] edge_exp [0:3] = '{32'h1, 32'h1, 32'h2, 32'h5};

  tcx_core #(.CW(16)) i_dut (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trig_i(trig_i), .ov_o(ov_o),
    .un_o(un_o), .cc_o(cc_o), .irq_o(irq_o), .line_o(line_o), .line_compl_o(line_compl_o)
  );
  tcx_trig_src i_src (.sys_clk_i(sys_clk_i), .trig_o(trig_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // output trigger pulses are counted in cycles, so their length is checked
  always @(posedge sys_clk_i) begin
    if (ov_o === 1'b1) ov_hi <= ov_hi + 1;
    if (un_o === 1'b1) un_hi <= un_hi + 1;
    if (cc_o === 1'b1) cc_hi <= cc_hi + 1;
  end
  // ==========================================
  // helpers
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    q = rdata_o;
  endtask
  task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(name, exp, q);
  endtask
  task cmd(input logic [4:0] m);
    wr(OFS_EV_CMD, {27'h0, m});
  endtask
  task cnt(input int n);
    repeat (n) cmd(5'h08);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task t_reset;
    rdc("trg_cfg", OFS_TRG_CFG, {22'h0, TRG_CFG_RST});
    rdc("period", OFS_PER, {16'h0, PER_RST});
    rdc("period_buf", OFS_PER_BUF, {16'h0, PER_RST});
    rdc("compare", OFS_CMP, {16'h0, CMP_RST});
    rdc("block_ctrl", OFS_BLK_CTRL, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
    chk("irq", 32'h0, {31'h0, irq_o});
  endtask
  task t_basic;
    wr(OFS_TALLY, 32'h5);
    cmd(5'h01);
    rdc("tally_off", OFS_TALLY, 32'h5);
    wr(OFS_CH_CTRL, 32'h0);
    wr(OFS_TRG_CFG, 32'h0);
    wr(OFS_BLK_CTRL, 32'h1);
    cmd(5'h01);
    rdc("reload_up", OFS_TALLY, 32'h0);
    cnt(3);
    rdc("count_up", OFS_TALLY, 32'h3);
    cmd(5'h04);
    cnt(1);
    rdc("stopped", OFS_TALLY, 32'h3);
    cmd(5'h02);
    rdc("resumed", OFS_TALLY, 32'h4);
    wr(OFS_BLK_CTRL, 32'h0);
    cnt(1);
    rdc("frozen", OFS_TALLY, 32'h4);
    rdc("cfg_kept", OFS_TRG_CFG, 32'h0);
    wr(OFS_BLK_CTRL, 32'h1);
    cnt(1);
    rdc("reenabled", OFS_TALLY, 32'h5);
  endtask
  task t_capture;
    base = cc_hi;
    cmd(5'h10);
    rdc("cap", OFS_CAP, 32'h5);
    cnt(1);
    cmd(5'h10);
    rdc("cap2", OFS_CAP, 32'h6);
    rdc("cap_buf", OFS_CAP_BUF, 32'h5);
    rdc("intr_cc", OFS_INTR, 32'h2);
    chk("irq_set", 32'h1, {31'h0, irq_o});
    wr(OFS_INTR, 32'h3);
    rdc("intr_clr", OFS_INTR, 32'h0);
    chk("irq_clr", 32'h0, {31'h0, irq_o});
    chk("cc_len", 32'h4, 32'(cc_hi - base));
  endtask
  task t_ovf;
    wr(OFS_PER, 32'h4);
    cmd(5'h01);
    base = ov_hi;
    cnt(5);
    rdc("wrap", OFS_TALLY, 32'h0);
    rd(OFS_INTR);
    chk("tc", 32'h1, q & 32'h1);
    tick(4);
    chk("ov_len", 32'h2, 32'(ov_hi - base));
    wr(OFS_INTR, 32'h3);
  endtask
  task t_dirs;
    wr(OFS_CH_CTRL, 32'h0001_0000);
    cmd(5'h01);
    rdc("reload_down", OFS_TALLY, 32'h0);
    wr(OFS_TALLY, 32'h2);
    base = un_hi;
    cnt(2);
    rdc("count_down", OFS_TALLY, 32'h0);
    cnt(1);
    tick(4);
    chk("un_len", 32'h2, 32'(un_hi - base));
    wr(OFS_CH_CTRL, 32'h0002_0000);
    cmd(5'h01);
    rdc("reload_updn", OFS_TALLY, 32'h1);
    // period is 4: up to 4, then the turn steps down to 3
    cnt(4);
    rdc("updn_turn", OFS_TALLY, 32'h3);
    rdc("status_down", OFS_STATUS, 32'h3);
  endtask
  task t_edges;
    wr(OFS_CH_CTRL, 32'h0);
    wr(OFS_PER, 32'hffff);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_TRG_CFG, 32'(s) << 6);
      cmd(5'h01);
      i_src.pulse(EV_COUNT, 5);
      tick(6);
      rd(OFS_TALLY);
      chk("edge_sel", edge_exp[s], q);
    end
  endtask
  // divided clock may catch one tick more or less at the window ends
  task t_div;
    wr(OFS_TRG_CFG, 32'h0c0);
    wr(OFS_CH_CTRL, 32'h0000_0200);
    cmd(5'h01);
    i_src.pulse(EV_COUNT, 40);
    tick(6);
    rd(OFS_TALLY);
    chk("div4", 32'h1, {31'h0, (q >= 9 && q <= 11)});
    wr(OFS_CH_CTRL, 32'h0500_0700);
    cmd(5'h01);
    i_src.pulse(EV_COUNT, 40);
    tick(6);
    rd(OFS_TALLY);
    chk("dt_undiv", 32'h1, {31'h0, (q >= 38 && q <= 41)});
  endtask
  task t_pwm;
    wr(OFS_CH_CTRL, 32'h0400_0000);
    wr(OFS_TRG_CFG, 32'h0);
    wr(OFS_CMP, 32'h8000);
    cmd(5'h01);
    tick(2);
    chk("line", 32'h1, {31'h0, line_o});
    cmd(5'h04);
    tick(2);
    chk("line_kill", 32'h0, {31'h0, line_o});
    chk("compl_kill", 32'h0, {31'h0, line_compl_o});
    cmd(5'h02);
    tick(2);
    chk("line_back", 32'h1, {31'h0, line_o});
    wr(OFS_CMP_BUF, 32'h1234);
    wr(OFS_PER_BUF, 32'h0777);
    cmd(5'h10);
    rdc("cmp_sw", OFS_CMP, 32'h1234);
    rdc("cmp_buf_sw", OFS_CMP_BUF, 32'h8000);
    rdc("per_sw", OFS_PER, 32'h0777);
    rdc("per_buf_sw", OFS_PER_BUF, 32'hffff);
    wr(OFS_CMP, 32'h0);
    tick(2);
    chk("compl_on", 32'h1, {31'h0, line_compl_o});
    chk("line_off", 32'h0, {31'h0, line_o});
  endtask
  // one forward quadrature cycle: a rises, b rises, a falls, b falls
  task t_quad;
    wr(OFS_CH_CTRL, 32'h0300_0000);
    wr(OFS_INTR, 32'h3);
    cmd(5'h01);
    rd(OFS_INTR);
    chk("quad_index", 32'h1, q & 32'h1);
    i_src.hold(EV_COUNT, 1'b1);
    tick(4);
    i_src.hold(EV_START, 1'b1);
    tick(4);
    i_src.hold(EV_COUNT, 1'b0);
    tick(4);
    i_src.hold(EV_START, 1'b0);
    tick(6);
    rdc("quad_pos", OFS_TALLY, 32'h4);
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    nrst_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    err_count = 0;
    samples_checked = 0;
    ov_hi = 0;
    un_hi = 0;
    cc_hi = 0;
    repeat (3) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    t_reset;
    t_basic;
    t_capture;
    t_ovf;
    t_dirs;
    t_edges;
    t_div;
    t_pwm;
    t_quad;
    stop_test;
  end
  // about 400 cycles are needed; fifty times that marks a hang
  initial begin
    #200000;
    err_count++;
    stop_test;
  end
endmodule
`default_nettype wire
